// file: include/amb_cfg.svh
// address map, field positions, register offsets, reset values and interrupt levels of the address-mapping block
`ifndef AMB_CFG_SVH
`define AMB_CFG_SVH

// processor address and map geometry
`define AMB_VADDR_W        24
`define AMB_PADDR_W        23
`define AMB_SPACE_BIT      23
`define AMB_MAP_DEPTH      4096
`define AMB_MAP_IDX_W      12
`define AMB_MAP_ENTRY_W    20
`define AMB_PAGE_W         12
`define AMB_PROT_W         8
`define AMB_OFFSET_LSB     1
`define AMB_OFFSET_MSB     11
`define AMB_PAGE_LSB       12

// map entry fields
`define AMB_ENT_PAGE_MSB   19
`define AMB_ENT_PAGE_LSB   8
`define AMB_ENT_BUS        0
`define AMB_ENT_IO         1
`define AMB_ENT_WPROT      2
`define AMB_ENT_SUPER      3
`define AMB_ENT_VALID      4

// system space regions, selected by processor address bits 22..20
`define AMB_SYS_SEL_MSB    22
`define AMB_SYS_SEL_LSB    20
`define AMB_SYS_PROM       3'h0
`define AMB_SYS_MAP        3'h1
`define AMB_SYS_CTX        3'h2
`define AMB_SYS_BOOT_EXIT  3'h3
`define AMB_SYS_DEV        3'h4
`define AMB_SWAP_MSB       13
`define AMB_SWAP_LSB       2

// AXI4-Lite register byte offsets
`define AMB_REG_CONTEXT    4'h0
`define AMB_REG_STATUS     4'h4
`define AMB_REG_FAULT_ADDR 4'h8
`define AMB_AXI_ADDR_W     4

// status register fields
`define AMB_ST_BOOT        0
`define AMB_ST_FOUR_CTX    1
`define AMB_ST_LVL_LSB     4

// reset values and interrupt levels
`define AMB_CTX_RESET      2'h0
`define AMB_LVL_NMI        3'h7
`define AMB_LVL_REFRESH    7
`define AMB_LVL_TIMER      6
`define AMB_LVL_UART       5

`endif

// file: include/amb_pkg.sv
// types shared by the address-mapping and boot-control block
package amb_pkg;

  typedef enum logic [3:0] {
    AMB_TGT_NONE,
    AMB_TGT_PROM,
    AMB_TGT_RAM,
    AMB_TGT_BUS_MEM,
    AMB_TGT_BUS_IO,
    AMB_TGT_DEV,
    AMB_TGT_MAP,
    AMB_TGT_CTX,
    AMB_TGT_BOOT_EXIT
  } amb_target_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        write;
    logic        supervisor;
    logic [31:0] wdata;
  } amb_cpu_req_t;

  typedef struct packed {
    logic [22:0] phys_addr;
    amb_target_t target;
    logic        page_bus;
    logic        page_io;
    logic [7:0]  prot;
    logic        fault;
    logic [31:0] rdata;
  } amb_cpu_resp_t;

endpackage : amb_pkg

// file: logic/amb_top.sv
// address mapping, boot overlay and interrupt gating for the processor board
`timescale 1ns/10ps
`default_nettype none
`include "amb_cfg.svh"

module amb_top #(
  parameter int MAP_DEPTH = `AMB_MAP_DEPTH,
  parameter int SYNC_W    = 7
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // processor side, same clock
  input  wire logic                  cpu_req_valid,
  input  wire amb_pkg::amb_cpu_req_t cpu_req,
  output logic                       cpu_resp_valid,
  output amb_pkg::amb_cpu_resp_t     cpu_resp,
  input  wire logic                  four_ctx_mode,
  input  wire logic [2:0]            cpu_mask,
  input  wire logic                  cpu_iack,
  output logic                       cpu_avec,
  output logic [2:0]                 cpu_ipl,
  // interrupt pins from outside the clock domain
  input  wire logic [SYNC_W:1]       bus_int,
  input  wire logic                  refresh_tick,
  input  wire logic                  user_timer_irq,
  input  wire logic                  uart_irq,
  // other bus masters, decoded target already local
  input  wire logic                  ext_req,
  input  wire logic                  ext_target_local,
  output logic                       ext_grant,
  output logic                       ext_deny,
  // AXI4-Lite register slave
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // highest set level of a request vector, zero when none
  function automatic logic [2:0] top_level(input logic [7:1] req);
    logic [2:0] lvl;
    lvl = 3'h0;
    for (int i = 1; i <= 7; i++) begin
      if (req[i]) begin
        lvl = 3'(i);
      end
    end
    return lvl;
  endfunction : top_level

  // map index for a managed access in either context arrangement
  function automatic logic [11:0] managed_index(input logic [23:0] a, input logic [1:0] ctx,
                                                input logic four);
    logic [11:0] idx;
    if (four) begin
      idx = {ctx[1], ctx[0], a[21:12]};
    end else begin
      idx = {ctx[0], a[22:12]};
    end
    return idx;
  endfunction : managed_index

  // ---------------------------------------------------------------- state
  logic [`AMB_MAP_ENTRY_W-1:0] map_mem [MAP_DEPTH];
  logic                        boot_state;
  logic [1:0]                  context_bits;
  logic [23:0]                 fault_addr;
  logic [SYNC_W:1]             int_s1;
  logic [SYNC_W:1]             int_s2;
  logic [SYNC_W:1]             int_s3;
  logic [SYNC_W:1]             int_level;

  // ---------------------------------------------------------------- decode
  wire logic [23:0] va         = cpu_req.addr;
  wire logic        is_system  = va[`AMB_SPACE_BIT];
  wire logic [2:0]  sys_sel    = va[`AMB_SYS_SEL_MSB:`AMB_SYS_SEL_LSB];
  wire logic [11:0] sys_index  = va[`AMB_SWAP_MSB:`AMB_SWAP_LSB];
  wire logic [11:0] mgd_index  = managed_index(va, context_bits, four_ctx_mode);
  wire logic [11:0] map_index  = is_system ? sys_index : mgd_index;
  wire logic [19:0] entry      = map_mem[map_index];
  wire logic [11:0] page       = entry[`AMB_ENT_PAGE_MSB:`AMB_ENT_PAGE_LSB];
  wire logic [7:0]  prot       = entry[`AMB_PROT_W-1:0];
  wire logic        pg_bus     = entry[`AMB_ENT_BUS];
  wire logic        pg_io      = entry[`AMB_ENT_IO];
  wire logic [22:0] mapped_pa  = {page, va[`AMB_OFFSET_MSB:`AMB_OFFSET_LSB]};
  wire logic [22:0] plain_pa   = va[`AMB_PADDR_W:`AMB_OFFSET_LSB];

  // every managed target passes the same protection check once the boot state has ended
  wire logic prot_fault = ~prot[`AMB_ENT_VALID]
                        | (cpu_req.write & prot[`AMB_ENT_WPROT])
                        | (~cpu_req.supervisor & prot[`AMB_ENT_SUPER]);
  wire logic sys_fault  = ~cpu_req.supervisor;

  wire logic boot_read  = boot_state & ~cpu_req.write & ~is_system;
  wire logic boot_write = boot_state & cpu_req.write & ~is_system;

  amb_pkg::amb_target_t mgd_target;
  amb_pkg::amb_target_t sys_target;
  amb_pkg::amb_target_t next_target;
  logic                 next_fault;
  logic [22:0]          next_pa;

  always_comb begin
    case ({pg_bus, pg_io})
      2'b00:   mgd_target = amb_pkg::AMB_TGT_RAM;
      2'b01:   mgd_target = amb_pkg::AMB_TGT_BUS_IO;
      2'b10:   mgd_target = amb_pkg::AMB_TGT_BUS_MEM;
      default: mgd_target = amb_pkg::AMB_TGT_BUS_IO;
    endcase
  end

  always_comb begin
    case (sys_sel)
      `AMB_SYS_PROM:      sys_target = amb_pkg::AMB_TGT_PROM;
      `AMB_SYS_MAP:       sys_target = amb_pkg::AMB_TGT_MAP;
      `AMB_SYS_CTX:       sys_target = amb_pkg::AMB_TGT_CTX;
      `AMB_SYS_BOOT_EXIT: sys_target = amb_pkg::AMB_TGT_BOOT_EXIT;
      `AMB_SYS_DEV:       sys_target = amb_pkg::AMB_TGT_DEV;
      default:            sys_target = amb_pkg::AMB_TGT_NONE;
    endcase
  end

  // boot overlay bypasses the map, which is not yet programmed
  always_comb begin
    if (is_system) begin
      next_target = sys_fault ? amb_pkg::AMB_TGT_NONE : sys_target;
      next_fault  = sys_fault | (sys_target == amb_pkg::AMB_TGT_NONE);
      next_pa     = plain_pa;
    end else if (boot_read) begin
      next_target = amb_pkg::AMB_TGT_PROM;
      next_fault  = 1'b0;
      next_pa     = plain_pa;
    end else if (boot_write) begin
      next_target = amb_pkg::AMB_TGT_RAM;
      next_fault  = 1'b0;
      next_pa     = plain_pa;
    end else begin
      next_target = prot_fault ? amb_pkg::AMB_TGT_NONE : mgd_target;
      next_fault  = prot_fault;
      next_pa     = mapped_pa;
    end
  end

  wire logic sys_ok      = cpu_req_valid & is_system & ~sys_fault;
  wire logic map_wr      = sys_ok & cpu_req.write & (sys_target == amb_pkg::AMB_TGT_MAP);
  wire logic ctx_wr      = sys_ok & cpu_req.write & (sys_target == amb_pkg::AMB_TGT_CTX);
  wire logic boot_exit   = sys_ok & cpu_req.write & (sys_target == amb_pkg::AMB_TGT_BOOT_EXIT);

  logic [31:0] next_rdata;
  always_comb begin
    case (next_target)
      amb_pkg::AMB_TGT_MAP: next_rdata = {12'h000, entry};
      amb_pkg::AMB_TGT_CTX: next_rdata = {30'h00000000, context_bits};
      default:              next_rdata = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------- processor answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_resp_valid <= 1'b0;
      cpu_resp       <= '0;
    end else begin
      cpu_resp_valid <= cpu_req_valid;
      if (cpu_req_valid) begin
        cpu_resp.phys_addr <= next_pa;
        cpu_resp.target    <= next_target;
        cpu_resp.page_bus  <= pg_bus & ~is_system & ~boot_state;
        cpu_resp.page_io   <= pg_io & ~is_system & ~boot_state;
        cpu_resp.prot      <= (is_system | boot_state) ? 8'h00 : prot;
        cpu_resp.fault     <= next_fault;
        cpu_resp.rdata     <= next_rdata;
      end
    end
  end

  // map array has no reset; software fills it during boot
  always_ff @(posedge aclk) begin
    if (map_wr) begin
      map_mem[sys_index] <= cpu_req.wdata[`AMB_MAP_ENTRY_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_state <= 1'b1;
    end else if (boot_exit) begin
      boot_state <= 1'b0;
    end
  end

  // ---------------------------------------------------------------- AXI4-Lite slave
  logic        aw_held;
  logic [3:0]  aw_addr_q;
  logic        w_held;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  wire logic do_write   = aw_held & w_held & ~s_axi_bvalid;
  wire logic wr_ctx     = do_write & (aw_addr_q == `AMB_REG_CONTEXT);
  wire logic wr_known   = (aw_addr_q == `AMB_REG_CONTEXT);
  wire logic rd_take    = s_axi_arvalid & s_axi_arready;

  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (s_axi_awvalid & ~aw_held) begin
      aw_held   <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held   <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid & ~w_held) begin
      w_held   <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // processor write wins over a simultaneous software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      context_bits <= `AMB_CTX_RESET;
    end else if (ctx_wr) begin
      context_bits <= cpu_req.wdata[1:0];
    end else if (wr_ctx & w_strb_q[0]) begin
      context_bits <= w_data_q[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_addr <= 24'h000000;
    end else if (cpu_req_valid & next_fault) begin
      fault_addr <= va;
    end
  end

  logic [31:0] rd_mux;
  logic        rd_known;
  always_comb begin
    rd_known = 1'b1;
    case (s_axi_araddr)
      `AMB_REG_CONTEXT:    rd_mux = {30'h00000000, context_bits};
      `AMB_REG_STATUS:     rd_mux = {25'h0000000, cpu_ipl, 2'h0, four_ctx_mode, boot_state};
      `AMB_REG_FAULT_ADDR: rd_mux = {8'h00, fault_addr};
      default: begin
        rd_mux   = 32'h00000000;
        rd_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------- interrupts
  // level 0 is never driven, so the loop starts at one
  wire logic [SYNC_W:1] raw_int;
  genvar g;
  generate
    for (g = 1; g <= SYNC_W; g++) begin : g_int
      if (g == `AMB_LVL_REFRESH) begin : g_ref
        assign raw_int[g] = bus_int[g] | refresh_tick;
      end else if (g == `AMB_LVL_TIMER) begin : g_tmr
        assign raw_int[g] = bus_int[g] | user_timer_irq;
      end else if (g == `AMB_LVL_UART) begin : g_urt
        assign raw_int[g] = bus_int[g] | uart_irq;
      end else begin : g_bus
        assign raw_int[g] = bus_int[g];
      end

      // a change counts only once stages two and three agree
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          int_s1[g]    <= 1'b0;
          int_s2[g]    <= 1'b0;
          int_s3[g]    <= 1'b0;
          int_level[g] <= 1'b0;
        end else begin
          int_s1[g] <= raw_int[g];
          int_s2[g] <= int_s1[g];
          int_s3[g] <= int_s2[g];
          if (int_s2[g] == int_s3[g]) begin
            int_level[g] <= int_s3[g];
          end
        end
      end
    end
  endgenerate

  wire logic [2:0] pend_level = top_level(int_level);
  wire logic       level_ok   = (pend_level == `AMB_LVL_NMI) | (pend_level > cpu_mask);
  wire logic [2:0] next_ipl   = (boot_state | ~level_ok) ? 3'h0 : pend_level;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_ipl <= 3'h0;
    end else begin
      cpu_ipl <= next_ipl;
    end
  end

  // no source ever supplies a vector
  assign cpu_avec = cpu_iack;

  // ---------------------------------------------------------------- other masters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_grant <= 1'b0;
      ext_deny  <= 1'b0;
    end else begin
      ext_grant <= ext_req & ~ext_target_local;
      ext_deny  <= ext_req & ext_target_local;
    end
  end

endmodule : amb_top
`default_nettype wire

// file: tb/amb_cpu_model.sv
// processor core model issuing one access at a time
`timescale 1ns/10ps
`default_nettype none
module amb_cpu_model (
  input  wire logic                   aclk,
  output logic                        cpu_req_valid,
  output amb_pkg::amb_cpu_req_t       cpu_req,
  input  wire logic                   cpu_resp_valid,
  input  wire amb_pkg::amb_cpu_resp_t cpu_resp
);
  initial begin
    cpu_req_valid = 1'b0;
    cpu_req       = '0;
  end
  task automatic access(input amb_pkg::amb_cpu_req_t r, output amb_pkg::amb_cpu_resp_t s);
    @(posedge aclk);
    cpu_req_valid <= 1'b1;
    cpu_req       <= r;
    @(posedge aclk);
    cpu_req_valid <= 1'b0;
    // released bus shows the inverse, never a stale copy
    cpu_req       <= ~r;
    #1;
    s = cpu_resp_valid ? cpu_resp : 'x;
  endtask : access
endmodule : amb_cpu_model
`default_nettype wire

// file: tb/amb_top_assertions.sv
// port-level checks for the address-mapping block
`timescale 1ns/10ps
`default_nettype none
module amb_chk (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   cpu_req_valid,
  input wire amb_pkg::amb_cpu_req_t  cpu_req,
  input wire logic                   cpu_resp_valid,
  input wire amb_pkg::amb_cpu_resp_t cpu_resp,
  input wire logic [2:0]             cpu_mask,
  input wire logic                   cpu_iack,
  input wire logic                   cpu_avec,
  input wire logic [2:0]             cpu_ipl,
  input wire logic                   ext_req,
  input wire logic                   ext_target_local,
  input wire logic                   ext_grant,
  input wire logic                   ext_deny
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic boot;
  wire  sys_req = cpu_req_valid && cpu_req.addr[23];
  wire  mgd_req = cpu_req_valid && !cpu_req.addr[23];
  wire  exit_wr = sys_req && cpu_req.write && cpu_req.supervisor && cpu_req.addr[22:20] == 3'h3;
  always_ff @(posedge aclk) begin
    if (!aresetn) boot <= 1'b1;
    else if (exit_wr) boot <= 1'b0;
  end
  sys_space_a: assert property (
    sys_req |=> !(cpu_resp.target inside {amb_pkg::AMB_TGT_RAM, amb_pkg::AMB_TGT_BUS_MEM, amb_pkg::AMB_TGT_BUS_IO}))
    else $error("system access reached a managed target");
  managed_space_a: assert property (
    mgd_req && !boot |=> cpu_resp.target inside {amb_pkg::AMB_TGT_NONE, amb_pkg::AMB_TGT_RAM,
      amb_pkg::AMB_TGT_BUS_MEM, amb_pkg::AMB_TGT_BUS_IO}) else $error("managed access hit system target");
  phys_low_a: assert property (
    mgd_req |=> cpu_resp.fault || cpu_resp.phys_addr[10:0] == $past(cpu_req.addr[11:1]))
    else $error("low physical bits not passed through");
  boot_read_a: assert property (
    mgd_req && boot && !cpu_req.write |=> cpu_resp.target == amb_pkg::AMB_TGT_PROM)
    else $error("boot read not served from prom");
  boot_write_a: assert property (
    mgd_req && boot && cpu_req.write |=> cpu_resp.target == amb_pkg::AMB_TGT_RAM)
    else $error("boot write not sent to ram");
  boot_irq_a: assert property (boot |-> cpu_ipl == 3'h0)
    else $error("interrupt shown in boot state");
  user_sys_a: assert property (
    sys_req && !cpu_req.supervisor |=> cpu_resp.fault && cpu_resp.target == amb_pkg::AMB_TGT_NONE)
    else $error("user system access not refused");
  auto_vector_a: assert property (cpu_avec == cpu_iack)
    else $error("acknowledge not autovectored");
  ext_local_a: assert property (
    ext_req && ext_target_local |=> ext_deny && !ext_grant) else $error("other master reached local");
  mask_level_a: assert property (
    cpu_ipl inside {[3'h1:3'h6]} && $past(cpu_mask) == cpu_mask && $past(cpu_mask, 2) == cpu_mask
      |-> cpu_ipl > cpu_mask) else $error("masked level shown");
  reset_quiet_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> cpu_ipl == 3'h0 && !cpu_resp_valid) else $error("outputs active in reset");
  cover property (exit_wr);
  cover property (cpu_ipl == 3'h7);
  cover property (cpu_resp_valid && cpu_resp.fault);
endmodule : amb_chk
bind amb_top amb_chk u_amb_chk (.*);
`default_nettype wire

// file: tb/tb_amb_top.sv
// self-checking bench for the address-mapping block
`timescale 1ns/10ps
`default_nettype none
module tb_amb_top;
  logic        aclk, aresetn, four_ctx_mode, cpu_iack, refresh_tick, user_timer_irq, uart_irq;
  logic        ext_req, ext_target_local, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready;
  logic [2:0]  cpu_mask;
  logic [7:1]  bus_int;
  logic [3:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [1:0]  rr;
  wire logic   cpu_req_valid, cpu_resp_valid, cpu_avec, ext_grant, ext_deny;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [2:0]  cpu_ipl;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire amb_pkg::amb_cpu_req_t  cpu_req;
  wire amb_pkg::amb_cpu_resp_t cpu_resp;
  amb_pkg::amb_cpu_resp_t      rs;
  int failures = 0, checks_done = 0, cycles = 0;

  amb_top       u_amb_top (.*, .s_axi_wstrb(4'hf));
  amb_cpu_model u_amb_cpu_model (.*);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    // far above the few hundred cycles the tests need
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cpu(input logic [23:0] a, input logic w, s, input logic [31:0] d);
    u_amb_cpu_model.access('{a, w, s, d}, rs);
  endtask : cpu
  task automatic map_wr(input logic [11:0] i, input logic [19:0] e);
    cpu({8'h90, 2'h0, i, 2'h0}, 1'b1, 1'b1, {12'h0, e});
    chk("map write target", 32'(amb_pkg::AMB_TGT_MAP), 32'(rs.target));
  endtask : map_wr
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready === 1'b1;
      w  = s_axi_wvalid && s_axi_wready === 1'b1;
      b  = s_axi_bvalid === 1'b1;
      rr = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    logic h, b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!b) begin
      @(negedge aclk);
      h  = s_axi_arvalid && s_axi_arready === 1'b1;
      b  = s_axi_rvalid === 1'b1;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (h) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic t_boot;
    axi_rd(4'h4);
    chk("status after reset", 32'h1, rd & 32'h73);
    axi_rd(4'h0);
    chk("context after reset", 32'h0, rd);
    axi_rd(4'hc);
    chk("unmapped response", 32'h2, 32'(rr));
    axi_wr(4'h4, 32'h0);
    chk("read-only write response", 32'h2, 32'(rr));
    cpu(24'h000000, 1'b0, 1'b1, 32'h0);
    chk("boot read target", 32'(amb_pkg::AMB_TGT_PROM), 32'(rs.target));
    chk("boot read address", 32'h0, 32'(rs.phys_addr));
    cpu(24'h000100, 1'b1, 1'b1, 32'h5);
    chk("boot write target", 32'(amb_pkg::AMB_TGT_RAM), 32'(rs.target));
    @(posedge aclk);
    refresh_tick <= 1'b1;
    repeat (12) @(negedge aclk);
    chk("boot level", 32'h0, 32'(cpu_ipl));
    $display("test boot done");
  endtask : t_boot
  task automatic t_map;
    map_wr(12'hb45, 20'habc10);
    map_wr(12'h345, 20'h12311);
    map_wr(12'h146, 20'h00000);
    cpu(24'h902d14, 1'b0, 1'b1, 32'h0);
    chk("map readback", 32'habc10, rs.rdata & 32'hfffff);
    axi_wr(4'h0, 32'h1);
    chk("context write response", 32'h0, 32'(rr));
    axi_rd(4'h0);
    chk("context write", 32'h1, rd & 32'h3);
    cpu(24'hb00000, 1'b1, 1'b1, 32'h0);
    axi_rd(4'h4);
    chk("boot cleared", 32'h0, rd & 32'h1);
    repeat (8) @(negedge aclk);
    chk("level seven after boot", 32'h7, 32'(cpu_ipl));
    cpu(24'h345678, 1'b0, 1'b1, 32'h0);
    chk("ctx1 target", 32'(amb_pkg::AMB_TGT_RAM), 32'(rs.target));
    chk("ctx1 phys", 32'({12'habc, 11'h33c}), 32'(rs.phys_addr));
    chk("ctx1 prot", 32'h10, 32'(rs.prot));
    axi_wr(4'h0, 32'h0);
    cpu(24'h345678, 1'b1, 1'b0, 32'h0);
    chk("ctx0 target", 32'(amb_pkg::AMB_TGT_BUS_MEM), 32'(rs.target));
    chk("ctx0 page bus", 32'h1, 32'(rs.page_bus));
    chk("ctx0 phys", 32'({12'h123, 11'h33c}), 32'(rs.phys_addr));
    cpu(24'h146000, 1'b0, 1'b1, 32'h0);
    chk("invalid page fault", 32'h1, 32'(rs.fault));
    $display("test map done");
  endtask : t_map
  task automatic t_four;
    @(posedge aclk);
    {four_ctx_mode, refresh_tick, aresetn} <= 3'h4;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(4'h4);
    chk("status four", 32'h3, rd & 32'h73);
    map_wr(12'h945, 20'h5a512);
    axi_wr(4'h0, 32'h2);
    cpu(24'hb00000, 1'b1, 1'b1, 32'h0);
    cpu(24'h145678, 1'b0, 1'b1, 32'h0);
    chk("four ctx target", 32'(amb_pkg::AMB_TGT_BUS_IO), 32'(rs.target));
    chk("four ctx io", 32'h1, 32'(rs.page_io));
    chk("four ctx phys", 32'({12'h5a5, 11'h33c}), 32'(rs.phys_addr));
    // valid, supervisor-only and write-protected page
    map_wr(12'h946, 20'h0001c);
    cpu(24'h146000, 1'b0, 1'b0, 32'h0);
    chk("user on supervisor page", 32'h1, 32'(rs.fault));
    cpu(24'h146000, 1'b1, 1'b1, 32'h0);
    chk("write to protected page", 32'h1, 32'(rs.fault));
    cpu(24'h146000, 1'b0, 1'b1, 32'h0);
    chk("supervisor page read", 32'(amb_pkg::AMB_TGT_RAM), 32'(rs.target));
    cpu(24'h900000, 1'b0, 1'b0, 32'h0);
    chk("user system fault", 32'h1, 32'(rs.fault));
    axi_rd(4'h8);
    chk("fault address", 32'h900000, rd & 32'hffffff);
    cpu(24'ha00000, 1'b1, 1'b1, 32'h3);
    axi_rd(4'h0);
    chk("context via system", 32'h3, rd);
    cpu(24'ha00000, 1'b0, 1'b1, 32'h0);
    chk("context system read", 32'h3, rs.rdata);
    cpu(24'h800000, 1'b0, 1'b1, 32'h0);
    chk("system prom target", 32'(amb_pkg::AMB_TGT_PROM), 32'(rs.target));
    cpu(24'hc00000, 1'b0, 1'b1, 32'h0);
    chk("system device target", 32'(amb_pkg::AMB_TGT_DEV), 32'(rs.target));
    cpu(24'hd00000, 1'b0, 1'b1, 32'h0);
    chk("unused system fault", 32'h1, 32'(rs.fault));
    $display("test four done");
  endtask : t_four
  task automatic t_irq;
    logic [2:0] m [6] = '{3'h7, 3'h7, 3'h4, 3'h4, 3'h5, 3'h0};
    // refresh, timer, uart, bus line one
    logic [3:0] s [6] = '{4'h2, 4'ha, 4'h6, 4'h2, 4'h2, 4'h1};
    logic [2:0] e [6] = '{3'h0, 3'h7, 3'h6, 3'h5, 3'h0, 3'h1};
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      cpu_mask <= m[i];
      {refresh_tick, user_timer_irq, uart_irq, bus_int[1]} <= s[i];
      repeat (10) @(negedge aclk);
      chk("level", 32'(e[i]), 32'(cpu_ipl));
    end
    @(posedge aclk);
    cpu_iack <= 1'b1;
    @(negedge aclk);
    chk("autovector", 32'h1, 32'(cpu_avec));
    @(posedge aclk);
    {cpu_iack, ext_req, ext_target_local} <= 3'h3;
    repeat (2) @(negedge aclk);
    chk("local denied", 32'h2, 32'({ext_deny, ext_grant}));
    @(posedge aclk);
    ext_target_local <= 1'b0;
    repeat (2) @(negedge aclk);
    chk("bus granted", 32'h1, 32'({ext_deny, ext_grant}));
    $display("test interrupts done");
  endtask : t_irq
  initial begin
    {aresetn, four_ctx_mode, cpu_iack, refresh_tick, user_timer_irq, uart_irq} = '0;
    {ext_req, ext_target_local, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, bus_int} = '0;
    cpu_mask = 3'h7;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_boot();
    t_map();
    t_four();
    t_irq();
    finish_test();
  end
endmodule : tb_amb_top
`default_nettype wire
